// ===== hw/rss_semaphore.sv
`timescale 1ns/10ps
// Notes on behaviour
// - first driver read of semaphore bit returns 0 and sets it; write 0 clears
// - driver nvm lock set refused while firmware lock held; soft reset clears
// - wake bit pulses the manageability clock wake and reads back 0
// - firmware nvm lock set succeeds only while driver lock is clear
// - valid flag cleared by reset; firmware sets it after boot
// - driver can only set word unlock bit 28 of firmware register; firmware reset clears bits 15:0
// - ten ownership bits are plain read/write storage, no locking
// - register lock bit reads 0 then sets; writing 0 clears it
// - ownership bits reset on power-on and lan power good only
// - ownership bit map: driver 4:0, firmware 8:5, bit 9 spare
module rss_semaphore (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  // host register bus
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // firmware register port, same clock
  input  wire logic        fw_req,
  input  wire logic        fw_write,
  input  wire logic [31:0] fw_addr,
  input  wire logic [31:0] fw_wdata,
  output logic             fw_ack,
  output logic      [31:0] fw_rdata,
  // asynchronous reset sources
  input  wire logic        host_if_soft_reset,
  input  wire logic        fw_reset,
  input  wire logic        lan_power_good,
  // status towards the rest of the chip
  output logic             mgmt_clk_wake,
  output logic             sw_nvm_granted,
  output logic             fw_nvm_granted,
  output logic      [9:0]  resource_own_bits,
  output logic             fw_valid_flag
);

  // =====================================================================
  // pin synchronisers
  // =====================================================================
  logic [2:0] pins_s;
  logic       soft_rst_s;
  logic       fw_rst_s;
  logic       pwr_good_s;

  rss_sync #(
    .W (3)
  ) u_sync (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .async_in ({lan_power_good, fw_reset, host_if_soft_reset}),
    .sync_out (pins_s)
  );

  assign soft_rst_s = pins_s[0];
  assign fw_rst_s   = pins_s[1];
  assign pwr_good_s = pins_s[2];

  // =====================================================================
  // state
  // =====================================================================
  logic                   drv_sem_q,   drv_sem_d;
  logic                   sw_lock_q,   sw_lock_d;
  logic                   wake_q,      wake_d;
  logic [31:0]            firmware_semaphore_reg_q,      firmware_semaphore_reg_d;
  logic [9:0]             own_q,       own_d;
  logic                   reg_lock_q,  reg_lock_d;
  logic [31:0]            hrdata_q,    hrdata_d;
  logic [31:0]            fw_rdata_q,  fw_rdata_d;
  logic                   fw_ack_q,    fw_ack_d;
  logic                   dph_wr_q,    dph_wr_d;
  rss_pkg::rss_sel_t      dph_sel_q,   dph_sel_d;

  // =====================================================================
  // bus qualification
  // =====================================================================
  logic                   h_take;
  logic                   h_rd;
  logic                   h_wr;
  logic                   f_take;
  rss_pkg::rss_sel_t      h_sel;
  rss_pkg::rss_sel_t      f_sel;
  logic                   sw_set_req;
  logic                   fw_set_req;
  logic                   fw_set_win;

  // only whole-word transfers are taken; others complete with no effect
  assign h_take = hsel && hready && htrans[1] && clk_en && (hsize == rss_pkg::HSIZE_WORD);
  assign h_rd   = h_take && !hwrite;
  assign h_wr   = h_take && hwrite;
  assign f_take = fw_req && clk_en;
  assign h_sel  = rss_pkg::rss_decode(haddr);
  assign f_sel  = rss_pkg::rss_decode(fw_addr);

  // =====================================================================
  // next-state logic
  // =====================================================================
  // order matters: host write, firmware write, lock arbitration, reads, resets;
  // reads see this cycle's writes so a read right after a write is coherent
  always_comb begin
    drv_sem_d  = drv_sem_q;
    sw_lock_d  = sw_lock_q;
    wake_d     = 1'b0;
    firmware_semaphore_reg_d     = firmware_semaphore_reg_q;
    own_d      = own_q;
    reg_lock_d = reg_lock_q;
    hrdata_d   = hrdata_q;
    fw_rdata_d = fw_rdata_q;
    fw_ack_d   = f_take;
    dph_wr_d   = h_wr;
    dph_sel_d  = h_sel;
    sw_set_req = 1'b0;
    fw_set_req = 1'b0;
    fw_set_win = 1'b0;

    // host data phase write
    if (dph_wr_q) begin
      case (dph_sel_q)
        rss_pkg::RSS_SEL_DRV: begin
          if (!hwdata[rss_pkg::DRV_SEM_BIT]) begin
            drv_sem_d = 1'b0;
          end
          if (hwdata[rss_pkg::SW_LOCK_BIT]) begin
            sw_set_req = 1'b1;
          end else begin
            sw_lock_d = 1'b0;
          end
          wake_d = hwdata[rss_pkg::WAKE_BIT];
        end
        rss_pkg::RSS_SEL_FW: begin
          if (hwdata[rss_pkg::WORD_UNLOCK_BIT]) begin
            firmware_semaphore_reg_d[rss_pkg::WORD_UNLOCK_BIT] = 1'b1;
          end
        end
        rss_pkg::RSS_SEL_SHR: begin
          own_d = hwdata[rss_pkg::OWN_W-1:0];
          if (!hwdata[rss_pkg::REG_LOCK_BIT]) begin
            reg_lock_d = 1'b0;
          end
        end
        default: begin
          // unmapped write is dropped
        end
      endcase
    end

    // firmware write; the driver register is read-only to firmware
    if (f_take && fw_write) begin
      case (f_sel)
        rss_pkg::RSS_SEL_FW: begin
          firmware_semaphore_reg_d = (firmware_semaphore_reg_d & ~rss_pkg::FIRMWARE_SEMAPHORE_REG_IMPL_MASK) | (fw_wdata & rss_pkg::FIRMWARE_SEMAPHORE_REG_IMPL_MASK);
          firmware_semaphore_reg_d[rss_pkg::FW_LOCK_BIT] = firmware_semaphore_reg_q[rss_pkg::FW_LOCK_BIT];
          if (fw_wdata[rss_pkg::FW_LOCK_BIT]) begin
            fw_set_req = 1'b1;
          end else begin
            firmware_semaphore_reg_d[rss_pkg::FW_LOCK_BIT] = 1'b0;
          end
        end
        rss_pkg::RSS_SEL_SHR: begin
          // firmware write lands last, so it wins a same-cycle clash
          own_d = fw_wdata[rss_pkg::OWN_W-1:0];
          if (!fw_wdata[rss_pkg::REG_LOCK_BIT]) begin
            reg_lock_d = 1'b0;
          end
        end
        default: begin
          // ignored
        end
      endcase
    end

    // firmware set needs free driver lock
    if (fw_set_req && !sw_lock_q) begin
      firmware_semaphore_reg_d[rss_pkg::FW_LOCK_BIT] = 1'b1;
      fw_set_win = 1'b1;
    end
    // driver set refused under firmware lock
    if (sw_set_req && !firmware_semaphore_reg_q[rss_pkg::FW_LOCK_BIT] && !fw_set_win) begin
      sw_lock_d = 1'b1;
    end

    // host read, captured at the address phase edge
    if (h_rd) begin
      case (h_sel)
        rss_pkg::RSS_SEL_DRV: begin
          hrdata_d = '0;
          hrdata_d[rss_pkg::DRV_SEM_BIT] = drv_sem_d;
          hrdata_d[rss_pkg::SW_LOCK_BIT] = sw_lock_d;
          drv_sem_d = 1'b1;
        end
        rss_pkg::RSS_SEL_FW: begin
          hrdata_d = firmware_semaphore_reg_d;
        end
        rss_pkg::RSS_SEL_SHR: begin
          hrdata_d = {reg_lock_d, 21'h0, own_d};
          reg_lock_d = 1'b1;
        end
        default: begin
          hrdata_d = rss_pkg::RDATA_RST;
        end
      endcase
    end

    // firmware read; host read goes first so only one party sees lock free
    if (f_take && !fw_write) begin
      case (f_sel)
        rss_pkg::RSS_SEL_DRV: begin
          fw_rdata_d = {29'h0, 1'b0, sw_lock_d, drv_sem_d};
        end
        rss_pkg::RSS_SEL_FW: begin
          fw_rdata_d = firmware_semaphore_reg_d;
        end
        rss_pkg::RSS_SEL_SHR: begin
          fw_rdata_d = {reg_lock_d, 21'h0, own_d};
          reg_lock_d = 1'b1;
        end
        default: begin
          fw_rdata_d = rss_pkg::RDATA_RST;
        end
      endcase
    end

    if (soft_rst_s) begin
      drv_sem_d = 1'b0;
      sw_lock_d = 1'b0;
    end
    if (fw_rst_s) begin
      firmware_semaphore_reg_d = firmware_semaphore_reg_d & ~rss_pkg::FIRMWARE_SEMAPHORE_REG_FWRST_MASK;
    end
    if (!pwr_good_s) begin
      own_d = rss_pkg::OWN_RST;
    end
  end

  // =====================================================================
  // registers
  // =====================================================================
  // clock enable low freezes every flop, bus answers wait meanwhile
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      drv_sem_q  <= 1'b0;
      sw_lock_q  <= 1'b0;
      wake_q     <= 1'b0;
      firmware_semaphore_reg_q     <= rss_pkg::FIRMWARE_SEMAPHORE_REG_RST;
      own_q      <= rss_pkg::OWN_RST;
      reg_lock_q <= 1'b0;
      hrdata_q   <= rss_pkg::RDATA_RST;
      fw_rdata_q <= rss_pkg::RDATA_RST;
      fw_ack_q   <= 1'b0;
      dph_wr_q   <= 1'b0;
      dph_sel_q  <= rss_pkg::RSS_SEL_NONE;
    end else if (clk_en) begin
      drv_sem_q  <= drv_sem_d;
      sw_lock_q  <= sw_lock_d;
      wake_q     <= wake_d;
      firmware_semaphore_reg_q     <= firmware_semaphore_reg_d;
      own_q      <= own_d;
      reg_lock_q <= reg_lock_d;
      hrdata_q   <= hrdata_d;
      fw_rdata_q <= fw_rdata_d;
      fw_ack_q   <= fw_ack_d;
      dph_wr_q   <= dph_wr_d;
      dph_sel_q  <= dph_sel_d;
    end
  end

  // =====================================================================
  // outputs
  // =====================================================================
  // zero-wait slave; stalls only while the clock enable is low
  assign hreadyout         = clk_en;
  assign hresp             = rss_pkg::HRESP_OKAY;
  assign hrdata            = hrdata_q;
  assign fw_ack            = fw_ack_q;
  assign fw_rdata          = fw_rdata_q;
  assign mgmt_clk_wake     = wake_q;
  assign sw_nvm_granted    = sw_lock_q;
  assign fw_nvm_granted    = firmware_semaphore_reg_q[rss_pkg::FW_LOCK_BIT];
  assign resource_own_bits = own_q;
  assign fw_valid_flag     = firmware_semaphore_reg_q[rss_pkg::FW_VALID_BIT];

  // =====================================================================
  // assertions
  // =====================================================================
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  logic h_rd_drv;
  logic h_rd_shr;
  logic f_wr_shr;
  assign h_rd_drv = h_rd && (h_sel == rss_pkg::RSS_SEL_DRV) && !dph_wr_q && !soft_rst_s;
  assign h_rd_shr = h_rd && (h_sel == rss_pkg::RSS_SEL_SHR) && !dph_wr_q
                    && !(f_take && f_sel == rss_pkg::RSS_SEL_SHR);
  assign f_wr_shr = f_take && fw_write && (f_sel == rss_pkg::RSS_SEL_SHR);

  first_read_zero_a: assert property (
    h_rd_drv |=> drv_sem_q && (hrdata[0] == $past(drv_sem_q)))
    else $error("semaphore bit read did not return old value and set");

  soft_clears_a: assert property (
    (soft_rst_s && clk_en) |=> !drv_sem_q && !sw_lock_q)
    else $error("soft reset left driver bits set");

  sw_refused_a: assert property (
    $rose(sw_lock_q) |-> !$past(firmware_semaphore_reg_q[0]))
    else $error("driver lock set while firmware held it");

  wake_pulse_a: assert property (
    (clk_en && dph_wr_q && dph_sel_q == rss_pkg::RSS_SEL_DRV && hwdata[2])
      |=> mgmt_clk_wake ##1 (!mgmt_clk_wake || $past(dph_wr_q)))
    else $error("wake pulse missing or stuck");

  lock_exclusive_a: assert property (
    !(sw_lock_q && firmware_semaphore_reg_q[0]))
    else $error("both nvm locks held");

  fw_refused_a: assert property (
    $rose(firmware_semaphore_reg_q[0]) |-> !$past(sw_lock_q))
    else $error("firmware lock set while driver held it");

  fw_reset_low_a: assert property (
    (fw_rst_s && clk_en) |=> (firmware_semaphore_reg_q[15:0] == 16'h0000) && !fw_valid_flag)
    else $error("firmware reset left low half set");

  own_reset_a: assert property (
    (!pwr_good_s && clk_en) |=> (own_q == rss_pkg::OWN_RST))
    else $error("ownership bits survived power loss");

  own_storage_a: assert property (
    (f_wr_shr && pwr_good_s) |=> (resource_own_bits == $past(fw_wdata[9:0])))
    else $error("ownership bits did not store firmware write");

  reg_lock_read_a: assert property (
    (h_rd_shr && !reg_lock_q) |=> reg_lock_q && !hrdata[31])
    else $error("register lock read did not return 0 and set");

  cover_sw_grant: cover property ($rose(sw_nvm_granted));
  cover_fw_grant: cover property ($rose(fw_nvm_granted));
  cover_tie:      cover property (sw_set_req && fw_set_req);
  cover_wake:     cover property (mgmt_clk_wake);

endmodule : rss_semaphore

// ===== hw/rss_pkg.sv
// =====================================================================
// shared constants for the resource semaphore block
// =====================================================================
package rss_pkg;

  // register byte addresses on the host bus and the firmware port
  localparam logic [31:0] DRV_SEM_OFF     = 32'h0001_0140;
  localparam logic [31:0] FW_SEM_OFF      = 32'h0001_0148;
  localparam logic [31:0] SHARED_RES_OFF  = 32'h0001_0160;

  // driver_semaphore_reg fields
  localparam int          DRV_SEM_BIT     = 0;
  localparam int          SW_LOCK_BIT     = 1;
  localparam int          WAKE_BIT        = 2;

  // firmware_semaphore_reg fields
  localparam int          FW_LOCK_BIT     = 0;
  localparam int          FW_OPERATING_MODE_LSB     = 1;
  localparam int          FW_OPERATING_MODE_MSB     = 3;
  localparam int          NVM_RELOAD_BIT  = 6;
  localparam int          FW_VALID_BIT    = 15;
  localparam int          RST_CNT_LSB     = 16;
  localparam int          RST_CNT_MSB     = 18;
  localparam int          ERR_LSB         = 19;
  localparam int          ERR_MSB         = 24;
  localparam int          HOST_FAULT_BIT  = 25;
  localparam int          LAN0_FAULT_BIT  = 26;
  localparam int          LAN1_FAULT_BIT  = 27;
  localparam int          WORD_UNLOCK_BIT = 28;
  // implemented bits: 3:0, 6, 28:15
  localparam logic [31:0] FIRMWARE_SEMAPHORE_REG_IMPL_MASK  = 32'h1FFF_804F;
  // part cleared by a firmware reset
  localparam logic [31:0] FIRMWARE_SEMAPHORE_REG_FWRST_MASK = 32'h0000_FFFF;

  // firmware mode codes
  localparam logic [2:0]  MODE_MGMT_OFF   = 3'h0;
  localparam logic [2:0]  MODE_PASS_THRU  = 3'h2;
  localparam logic [2:0]  MODE_HOST_IF    = 3'h4;

  // shared_resource_reg fields
  localparam int          OWN_W           = 10;
  localparam int          REG_LOCK_BIT    = 31;
  localparam int          DRV_OWNS_NVM    = 0;
  localparam int          DRV_OWNS_PHY0   = 1;
  localparam int          DRV_OWNS_PHY1   = 2;
  localparam int          DRV_OWNS_SHREGS = 3;
  localparam int          DRV_OWNS_FLASH  = 4;
  localparam int          FW_OWNS_NVM     = 5;
  localparam int          FW_OWNS_PHY0    = 6;
  localparam int          FW_OWNS_PHY1    = 7;
  localparam int          FW_OWNS_SHREGS  = 8;

  // reset values
  localparam logic [31:0] FIRMWARE_SEMAPHORE_REG_RST        = 32'h0000_0000;
  localparam logic [9:0]  OWN_RST         = 10'h000;
  localparam logic [31:0] RDATA_RST       = 32'h0000_0000;

  // bus encodings
  localparam logic [2:0]  HSIZE_WORD      = 3'h2;
  localparam logic        HRESP_OKAY      = 1'b0;

  typedef enum logic [1:0] {
    RSS_SEL_NONE = 2'b00,
    RSS_SEL_DRV  = 2'b01,
    RSS_SEL_FW   = 2'b10,
    RSS_SEL_SHR  = 2'b11
  } rss_sel_t;

  // address decode shared by the host bus and the firmware port
  function automatic rss_sel_t rss_decode(input logic [31:0] addr);
    rss_sel_t sel;
    case (addr)
      DRV_SEM_OFF:    sel = RSS_SEL_DRV;
      FW_SEM_OFF:     sel = RSS_SEL_FW;
      SHARED_RES_OFF: sel = RSS_SEL_SHR;
      default:        sel = RSS_SEL_NONE;
    endcase
    return sel;
  endfunction : rss_decode

endpackage : rss_pkg

// ===== hw/rss_sync.sv
`timescale 1ns/10ps
// =====================================================================
// two-flop synchroniser for asynchronous pins
// =====================================================================
module rss_sync #(
  parameter int W = 3
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // first stage feeds only the second stage
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_comb begin
      meta_d[i] = async_in[i];
      sync_d[i] = meta_q[i];
    end
  end

  // both stages freeze with the clock enable
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (clk_en) begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule : rss_sync

// ===== tb/rss_fw_model.sv
`timescale 1ns/10ps
// =====================================================================
// firmware side model of the register port
// =====================================================================
module rss_fw_model (
  input  wire logic        ref_clk,
  output logic             fw_req,
  output logic             fw_write,
  output logic      [31:0] fw_addr,
  output logic      [31:0] fw_wdata,
  input  wire logic        fw_ack,
  input  wire logic [31:0] fw_rdata
);
  logic [31:0] fw_stat;  // last status, kept so lock writes do not wipe it

  // idle port at time zero
  initial begin
    fw_req   = 1'b0;
    fw_write = 1'b0;
    fw_addr  = 32'h0000_0000;
    fw_wdata = 32'h0000_0000;
    fw_stat  = 32'h0000_0000;
  end

  // one access; released lines are inverted so stale values never match
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge ref_clk);
    fw_req   <= 1'b1;
    fw_write <= w;
    fw_addr  <= a;
    fw_wdata <= d;
    @(posedge ref_clk);
    fw_req   <= 1'b0;
    fw_write <= ~w;
    fw_addr  <= ~a;
    fw_wdata <= ~d;
    // no fixed latency assumed; only the bench timeout ends a wait
    do begin
      @(posedge ref_clk);
    end while (fw_ack !== 1'b1);
    q = fw_rdata;
  endtask : xfer

  task automatic boot(input logic [2:0] mode, input logic [2:0] cnt, input logic [5:0] err,
                      input logic [2:0] flt, output logic [31:0] v);
    logic [31:0] q;
    fw_stat = {4'h0, flt, err, cnt, 1'b1, 8'h00, 1'b1, 2'b00, mode, 1'b0};
    v = fw_stat;
    xfer(1'b1, rss_pkg::FW_SEM_OFF, fw_stat, q);
  endtask : boot

  // millisecond back-off lies far beyond a run; caller retries at once
  task automatic lock(input logic on);
    logic [31:0] q;
    xfer(1'b1, rss_pkg::FW_SEM_OFF, {fw_stat[31:1], on}, q);
  endtask : lock
endmodule : rss_fw_model

// ===== tb/tb.sv
`timescale 1ns/10ps
// =====================================================================
// bench: host bus master, firmware model, checks
// =====================================================================
module tb;
  localparam logic [31:0] A_DRV = rss_pkg::DRV_SEM_OFF;
  localparam logic [31:0] A_FW  = rss_pkg::FW_SEM_OFF;
  localparam logic [31:0] A_SHR = rss_pkg::SHARED_RES_OFF;
  localparam logic [31:0] A_BAD = 32'h0001_0144;
  localparam int          LIMIT = 4000;  // run needs well under 1000 cycles

  logic        ref_clk, rst_b, clk_en, hsel, hwrite, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [2:0]  modes [3];
  logic [31:0] haddr, hwdata, hrdata, rv, q, v, pat;
  logic        fw_req, fw_write, fw_ack, host_if_soft_reset, fw_reset, lan_power_good;
  logic [31:0] fw_addr, fw_wdata, fw_rdata;
  logic        mgmt_clk_wake, sw_nvm_granted, fw_nvm_granted, fw_valid_flag;
  logic [9:0]  resource_own_bits;
  int          err_total, num_checks, cyc, wake_cnt;

  rss_semaphore rss_semaphore_i (
    .ref_clk            (ref_clk),
    .rst_b              (rst_b),
    .clk_en             (clk_en),
    .hsel               (hsel),
    .haddr              (haddr),
    .htrans             (htrans),
    .hwrite             (hwrite),
    .hsize              (hsize),
    .hwdata             (hwdata),
    .hready             (hreadyout),
    .hreadyout          (hreadyout),
    .hresp              (hresp),
    .hrdata             (hrdata),
    .fw_req             (fw_req),
    .fw_write           (fw_write),
    .fw_addr            (fw_addr),
    .fw_wdata           (fw_wdata),
    .fw_ack             (fw_ack),
    .fw_rdata           (fw_rdata),
    .host_if_soft_reset (host_if_soft_reset),
    .fw_reset           (fw_reset),
    .lan_power_good     (lan_power_good),
    .mgmt_clk_wake      (mgmt_clk_wake),
    .sw_nvm_granted     (sw_nvm_granted),
    .fw_nvm_granted     (fw_nvm_granted),
    .resource_own_bits  (resource_own_bits),
    .fw_valid_flag      (fw_valid_flag)
  );

  rss_fw_model rss_fw_model_i (
    .ref_clk  (ref_clk),
    .fw_req   (fw_req),
    .fw_write (fw_write),
    .fw_addr  (fw_addr),
    .fw_wdata (fw_wdata),
    .fw_ack   (fw_ack),
    .fw_rdata (fw_rdata)
  );

  // 200 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // hang guard and wake pulse counter
  always @(posedge ref_clk) begin
    cyc++;
    if (mgmt_clk_wake === 1'b1) wake_cnt++;
    if (cyc == LIMIT) begin
      err_total++;
      summarize();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // single word transfer; no fixed latency assumed
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge ref_clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do begin
      @(posedge ref_clk);
    end while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do begin
      @(posedge ref_clk);
    end while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb

  task automatic done(input string name);
    $display("test %s finished, mismatches so far %0d", name, err_total);
  endtask : done

  task automatic summarize();
    $display("checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = rss_pkg::HSIZE_WORD;
    hwdata = 32'h0000_0000;
    host_if_soft_reset = 1'b0;
    fw_reset = 1'b0;
    lan_power_good = 1'b1;
    err_total = 0;
    num_checks = 0;
    cyc = 0;
    wake_cnt = 0;
    modes[0] = rss_pkg::MODE_MGMT_OFF;
    modes[1] = rss_pkg::MODE_PASS_THRU;
    modes[2] = rss_pkg::MODE_HOST_IF;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    // reset values and driver semaphore bit
    ahb(1'b0, A_DRV, 32'h0, rv);
    check(rv, 32'h0);  // first read
    check({31'h0, hresp}, 32'h0);  // response always okay
    ahb(1'b0, A_DRV, 32'h0, rv);
    check(rv, 32'h1);  // set by read
    ahb(1'b1, A_DRV, 32'h0, rv);
    ahb(1'b0, A_DRV, 32'h0, rv);
    check(rv, 32'h0);  // cleared by write
    ahb(1'b0, A_FW, 32'h0, rv);
    check(rv, rss_pkg::FIRMWARE_SEMAPHORE_REG_RST);  // valid cleared
    ahb(1'b0, A_BAD, 32'h0, rv);
    check(rv, 32'h0);  // unmapped read returns 0
    check({31'h0, fw_valid_flag}, 32'h0);  // valid output low
    done("reset");
    // register lock bit and ownership storage
    ahb(1'b0, A_SHR, 32'h0, rv);
    check(rv, 32'h0);  // first read
    ahb(1'b0, A_SHR, 32'h0, rv);
    check(rv, 32'h8000_0000);  // set by read
    for (int i = 0; i < 3; i++) begin
      pat = (i == 0) ? 32'h155 : (i == 1) ? 32'h2AA : 32'h3E0;  // each bit both set and cleared
      ahb(1'b1, A_SHR, pat, rv);
      ahb(1'b0, A_SHR, 32'h0, rv);
      check(rv, pat);  // storage and lock clear
      check({22'h0, resource_own_bits}, pat);  // bit map on output
    end
    rss_fw_model_i.xfer(1'b0, A_SHR, 32'h0, q);
    check(q, 32'h8000_03E0);  // lock seen by firmware
    rss_fw_model_i.xfer(1'b1, A_SHR, 32'h0000_01E0, q);
    check({22'h0, resource_own_bits}, 32'h1E0);  // firmware write stored
    done("ownership");
    // nvm lock arbitration
    ahb(1'b1, A_DRV, 32'h2, rv);
    rss_fw_model_i.lock(1'b1);
    @(negedge ref_clk);
    check({30'h0, sw_nvm_granted, fw_nvm_granted}, 32'h2);  // firmware refused
    ahb(1'b0, A_DRV, 32'h0, rv);
    check(rv & 32'h2, 32'h2);  // readback grants
    ahb(1'b1, A_DRV, 32'h0, rv);
    rss_fw_model_i.lock(1'b1);
    ahb(1'b1, A_DRV, 32'h2, rv);
    ahb(1'b0, A_DRV, 32'h0, rv);
    check(rv & 32'h2, 32'h0);  // driver refused
    @(negedge ref_clk);
    check({30'h0, sw_nvm_granted, fw_nvm_granted}, 32'h1);  // firmware holds
    rss_fw_model_i.lock(1'b0);
    fork
      ahb(1'b1, A_DRV, 32'h2, rv);
      begin
        @(posedge ref_clk);
        rss_fw_model_i.lock(1'b1);
      end
    join
    @(negedge ref_clk);
    check({30'h0, sw_nvm_granted, fw_nvm_granted}, 32'h1);  // firmware wins
    rss_fw_model_i.lock(1'b0);
    done("arbitration");
    // wake request pulses once and reads back 0
    ahb(1'b1, A_DRV, 32'h4, rv);
    repeat (3) @(posedge ref_clk);
    check(32'(wake_cnt), 32'h1);  // single pulse
    ahb(1'b0, A_DRV, 32'h0, rv);
    check(rv & 32'h4, 32'h0);  // self clear
    done("wake");
    // firmware status register
    ahb(1'b1, A_FW, 32'hFFFF_FFFF, rv);
    ahb(1'b0, A_FW, 32'h0, rv);
    check(rv, 32'h1000_0000);  // host sets only unlock
    for (int i = 0; i < 15; i++) begin
      rss_fw_model_i.boot(modes[i % 3], 3'(i), (i == 14) ? 6'h3F : 6'(i), 3'(i), v);
      rss_fw_model_i.xfer(1'b0, A_FW, 32'h0, q);
      check(q, v);  // firmware readback
      ahb(1'b0, A_FW, 32'h0, rv);
      check(rv, v);  // host sees status
    end
    @(negedge ref_clk);
    check({31'h0, fw_valid_flag}, 32'h1);  // valid output
    fw_reset <= 1'b1;
    repeat (4) @(posedge ref_clk);
    fw_reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rss_fw_model_i.xfer(1'b0, A_FW, 32'h0, q);
    check(q, v & ~rss_pkg::FIRMWARE_SEMAPHORE_REG_FWRST_MASK);  // low half cleared
    check({31'h0, fw_valid_flag}, 32'h0);  // valid dropped
    done("status");
    // soft reset and power good
    ahb(1'b1, A_DRV, 32'h2, rv);
    ahb(1'b0, A_DRV, 32'h0, rv);
    check(rv & 32'h3, 32'h2);  // lock set, semaphore bit clear
    host_if_soft_reset <= 1'b1;
    repeat (4) @(posedge ref_clk);
    host_if_soft_reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    ahb(1'b0, A_DRV, 32'h0, rv);
    check(rv & 32'h3, 32'h0);  // soft reset clears
    check({22'h0, resource_own_bits}, 32'h1E0);  // other resets keep bits
    lan_power_good <= 1'b0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    check({22'h0, resource_own_bits}, 32'h0);  // power good clears
    lan_power_good <= 1'b1;
    repeat (4) @(posedge ref_clk);
    ahb(1'b0, A_SHR, 32'h0, rv);
    check(rv & 32'h3FF, 32'h0);  // stays clear
    done("resets");
    // driver claims resources while the clock enable stalls the bus
    ahb(1'b1, A_DRV, 32'h2, rv);  // win the nvm lock first
    ahb(1'b0, A_SHR, 32'h0, rv);
    check(rv & 32'h20, 32'h0);  // firmware nvm bit clear
    fork
      ahb(1'b1, A_SHR, 32'h11, rv);  // eeprom and flash claimed
      begin
        clk_en <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check({31'h0, hreadyout}, 32'h0);  // bus stalls while frozen
        clk_en <= 1'b1;
      end
    join
    ahb(1'b1, A_DRV, 32'h0, rv);  // release the nvm lock
    ahb(1'b0, A_SHR, 32'h0, rv);
    check(rv & 32'h3FF, 32'h11);  // claim stored after stall
    done("claim");
    summarize();
  end
endmodule : tb
